// file: design/ssp_port.sv
// Purpose: SPI-mode synchronous serial port with shift and buffer registers.
// Assumes: Software access as one-cycle strobes; timer tick is a one-cycle pulse.
// Notes: Slave clock must be slower than about a sixth of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ssp_port (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Software access
    input wire logic ctl_wr,
    input wire logic [7:0] ctl_wdata,
    input wire logic stat_wr,
    input wire logic [7:0] stat_wdata,
    input wire logic buf_wr,
    input wire logic [7:0] buf_wdata,
    input wire logic buf_rd,
    output logic [7:0] serial_control_one,
    output logic [7:0] serial_status_reg,
    output logic [7:0] serial_buffer_reg,
    output logic serial_irq_flag,
    input wire logic irq_clear,
    // Timer rate source
    input wire logic timer_tick,
    // Serial pins
    input wire logic sclk_in,
    input wire logic sdi,
    input wire logic ss_n,
    output var ssp_pkg::ssp_pins_s pins
);
    logic [7:0] ctl;
    logic [7:0] stat;
    logic [7:0] buf_q;
    logic [7:0] shreg;
    logic [3:0] bits;
    logic [4:0] div;
    logic tdiv;
    logic irq;
    logic sclk_o;
    logic sdo_o;
    logic sclk_q;
    ssp_pkg::ssp_state_e state;
    logic [7:0] next_ctl, next_stat, next_buf, next_shreg;
    logic [3:0] next_bits;
    logic [4:0] next_div;
    logic next_tdiv, next_irq, next_sclk_o, next_sdo_o, next_sclk_q;
    ssp_pkg::ssp_state_e next_state;
    logic sck_s, ss_s, sdi_s;

    // RULE_13 - clock and select sync
    ssp_sync u_sck (.clk_sys(clk_sys), .reset(reset), .init_level(1'b0),
        .din(sclk_in), .dout(sck_s));
    ssp_sync u_ss (.clk_sys(clk_sys), .reset(reset), .init_level(1'b1),
        .din(ss_n), .dout(ss_s));
    ssp_sync u_sdi (.clk_sys(clk_sys), .reset(reset), .init_level(1'b0),
        .din(sdi), .dout(sdi_s));

    // Mode decode used by several paths
    function automatic logic is_master(input logic [3:0] m);
        is_master = (m <= ssp_pkg::MODE_TIMER);
    endfunction
    // RULE_08 - only SPI codes act
    function automatic logic is_spi(input logic [3:0] m);
        is_spi = (m <= ssp_pkg::MODE_SLV_NOSEL);
    endfunction

    logic en, master, busy, pol, cke, ss_ok;
    logic rise_s, fall_s, lead_s, trail_s, tick, done;
    always_comb begin
        en = ctl[ssp_pkg::CTL_ENABLE] && is_spi(ctl[3:0]);
        master = is_master(ctl[3:0]);
        pol = ctl[ssp_pkg::CTL_POLARITY];
        cke = stat[ssp_pkg::STAT_EDGE];
        busy = (state != ssp_pkg::SSP_IDLE);
        // RULE_03 - select gates slave
        ss_ok = (ctl[3:0] != ssp_pkg::MODE_SLV_SEL) || !ss_s;
        rise_s = sck_s && !sclk_q;
        fall_s = !sck_s && sclk_q;
        // RULE_02 - leading edge by polarity
        lead_s = pol ? fall_s : rise_s;
        trail_s = pol ? rise_s : fall_s;
    end

    // RULE_12 - master rate select
    always_comb begin
        tick = 1'b0;
        unique case (ctl[3:0])
            ssp_pkg::MODE_DIV4: tick = (div >= ssp_pkg::HALF_DIV4);
            ssp_pkg::MODE_DIV16: tick = (div >= ssp_pkg::HALF_DIV16);
            ssp_pkg::MODE_DIV64: tick = (div >= ssp_pkg::HALF_DIV64);
            ssp_pkg::MODE_TIMER: tick = timer_tick && tdiv;
            default: tick = 1'b0;
        endcase
    end

    // ==========================================================
    // Transfer engine and software registers
    always_comb begin
        next_ctl = ctl;
        next_stat = stat;
        next_buf = buf_q;
        next_shreg = shreg;
        next_bits = bits;
        next_div = div;
        next_tdiv = tdiv;
        next_irq = irq;
        next_sclk_o = sclk_o;
        next_sdo_o = sdo_o;
        next_sclk_q = sck_s;
        next_state = state;
        done = 1'b0;
        // RULE_04 - control fully writable
        if (ctl_wr) begin
            next_ctl = ctl_wdata;
        end
        // RULE_04 - status low bits read-only
        if (stat_wr) begin
            next_stat = (stat & ~ssp_pkg::STAT_RW_MASK) | (stat_wdata & ssp_pkg::STAT_RW_MASK);
        end
        // RULE_11 - read clears full
        if (buf_rd) begin
            next_stat[ssp_pkg::STAT_FULL] = 1'b0;
        end
        if (irq_clear) begin
            next_irq = 1'b0;
        end
        if (!en) begin
            next_state = ssp_pkg::SSP_IDLE;
            next_sclk_o = pol;
            next_div = '0;
            next_bits = '0;
        end else begin
            unique case (state)
                ssp_pkg::SSP_IDLE: begin
                    next_sclk_o = pol;
                    next_div = '0;
                    next_bits = '0;
                    // Slave with cke=0 drives first bit once selected
                    next_sdo_o = shreg[7];
                    if (!master && ss_ok && lead_s) begin
                        next_state = ssp_pkg::SSP_LEAD;
                    end
                end
                ssp_pkg::SSP_LEAD, ssp_pkg::SSP_TRAIL: begin
                    if (master) begin
                        next_div = tick ? 5'h00 : div + 5'h01;
                        if (ctl[3:0] == ssp_pkg::MODE_TIMER && timer_tick) begin
                            next_tdiv = !tdiv;
                        end
                        if (tick) begin
                            next_sclk_o = !sclk_o;
                        end
                    end
                end
                default: next_state = ssp_pkg::SSP_IDLE;
            endcase
        end
        // RULE_09 - shift MSB first
        // Both ends pick edges from the edge bit; the sample-phase bit is only stored
        // Slave also samples while idle, since its first edge is what starts the byte
        if (en && (busy || !master)) begin
            if (master ? (tick && ((sclk_o == pol) ^ cke))
                    : (ss_ok && (cke ? trail_s : lead_s))) begin
                // RULE_01 - shift in one bit
                // Master data answers its own clock, so it skips the synchroniser delay
                next_shreg = {shreg[6:0], master ? sdi : sdi_s};
                next_bits = bits + 4'h1;
            end
            if (master ? (tick && ((sclk_o != pol) ^ cke))
                    : (ss_ok && (cke ? lead_s : trail_s))) begin
                next_sdo_o = next_shreg[7];
            end
            // Ending on the tick after the eighth sample keeps eight pulses in both phases
            if (master && tick && bits == ssp_pkg::BIT_COUNT) begin
                done = 1'b1;
            end
            if (!master && busy && bits == ssp_pkg::BIT_COUNT && !(cke ? trail_s : lead_s)) begin
                done = 1'b1;
            end
            if (!master && !ss_ok) begin
                next_state = ssp_pkg::SSP_IDLE;
                next_bits = '0;
            end
        end
        if (done) begin
            // RULE_06 - byte to buffer and flag
            next_state = ssp_pkg::SSP_IDLE;
            next_sclk_o = pol;
            next_irq = 1'b1;
            if (stat[ssp_pkg::STAT_FULL] && !buf_rd && !master) begin
                // Overflow keeps the old byte
                next_ctl[ssp_pkg::CTL_OVERFLOW] = 1'b1;
            end else begin
                next_buf = shreg;
                // RULE_11 - load sets full
                next_stat[ssp_pkg::STAT_FULL] = 1'b1;
            end
        end
        // RULE_05 - shift reg reached via buffer
        if (buf_wr) begin
            if (busy && !done) begin
                // RULE_10 - collision is sticky
                next_ctl[ssp_pkg::CTL_COLLISION] = 1'b1;
            end else begin
                // RULE_07 - write loads both
                next_buf = buf_wdata;
                next_shreg = buf_wdata;
                next_sdo_o = buf_wdata[7];
                next_bits = '0;
                if (en && master) begin
                    next_state = ssp_pkg::SSP_LEAD;
                    next_div = '0;
                    next_tdiv = 1'b0;
                end
            end
        end
    end

    // State registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctl <= ssp_pkg::CTL_RESET;
            stat <= ssp_pkg::STAT_RESET;
            buf_q <= 8'h00;
            shreg <= 8'h00;
            bits <= 4'h0;
            div <= 5'h00;
            tdiv <= 1'b0;
            irq <= 1'b0;
            sclk_o <= 1'b0;
            sdo_o <= 1'b0;
            sclk_q <= 1'b0;
            state <= ssp_pkg::SSP_IDLE;
        end else begin
            ctl <= next_ctl;
            stat <= next_stat;
            buf_q <= next_buf;
            shreg <= next_shreg;
            bits <= next_bits;
            div <= next_div;
            tdiv <= next_tdiv;
            irq <= next_irq;
            sclk_o <= next_sclk_o;
            sdo_o <= next_sdo_o;
            sclk_q <= next_sclk_q;
            state <= next_state;
        end
    end

    // Outputs; irq set beats a same-cycle clear through ordering above
    assign serial_control_one = ctl;
    assign serial_status_reg = stat;
    assign serial_buffer_reg = buf_q;
    assign serial_irq_flag = irq;
    assign pins.sclk = sclk_o;
    assign pins.sdo = sdo_o;
    assign pins.sclk_oe = en && master;
    assign pins.sdo_oe = en && (master || ss_ok);
endmodule // ssp_port
`default_nettype wire

// file: design/ssp_pkg.sv
// Purpose: Constants and carrier types for the serial shift buffer port.
// Assumes: 50 MHz system clock, synchronous active-high reset.
// Notes: Field positions follow the control and status byte layouts.
// Functional notes
// RULE_01 - Each transfer shifts one 8-bit word out while shifting one 8-bit word in.
// RULE_02 - All four clock polarity and phase combinations work, and both ends must use the same one.
// RULE_03 - The lines are data out, data in and serial clock, and a slave may add an active-low select.
// RULE_04 - Control is read/write, and in status the low six bits are read-only and the top two read/write.
// RULE_05 - Software cannot reach the shift register directly, only through the buffer.
// RULE_06 - A received byte is copied into the buffer and raises the interrupt flag.
// RULE_07 - A software write loads the buffer and the shift register together.
// RULE_08 - The port runs in SPI mode or in I2C mode, never both, and only SPI codes are acted on here.
// RULE_09 - Data shifts most significant bit first.
// RULE_10 - A buffer write during a transfer is dropped and sets a sticky collision flag.
// RULE_11 - Buffer full sets when a received byte is loaded and clears when software reads the buffer.
// RULE_12 - Mode codes 0000 to 0011 select master rates, 0100 slave with select and 0101 slave without.
// RULE_13 - In slave mode the external clock and select are synchronised before use.
package ssp_pkg;
    // ==========================================================
    // Control byte fields
    localparam int CTL_COLLISION = 7;
    localparam int CTL_OVERFLOW = 6;
    localparam int CTL_ENABLE = 5;
    localparam int CTL_POLARITY = 4;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] STAT_RW_MASK = 8'hC0;
    // ==========================================================
    // Status byte fields
    localparam int STAT_SAMPLE = 7;
    localparam int STAT_EDGE = 6;
    localparam int STAT_FULL = 0;
    // ==========================================================
    // Mode codes
    localparam logic [3:0] MODE_DIV4 = 4'h0;
    localparam logic [3:0] MODE_DIV16 = 4'h1;
    localparam logic [3:0] MODE_DIV64 = 4'h2;
    localparam logic [3:0] MODE_TIMER = 4'h3;
    localparam logic [3:0] MODE_SLV_SEL = 4'h4;
    localparam logic [3:0] MODE_SLV_NOSEL = 4'h5;
    // Half periods of the serial clock in system clocks, minus one, then bits per byte
    localparam logic [4:0] HALF_DIV4 = 5'h01;
    localparam logic [4:0] HALF_DIV16 = 5'h07;
    localparam logic [4:0] HALF_DIV64 = 5'h1F;
    localparam logic [3:0] BIT_COUNT = 4'h8;

    typedef struct packed {
        logic sclk;
        logic sdo;
        logic sclk_oe;
        logic sdo_oe;
    } ssp_pins_s;

    typedef enum logic [1:0] {
        SSP_IDLE,
        SSP_LEAD,
        SSP_TRAIL
    } ssp_state_e;
endpackage

// file: design/ssp_sync.sv
// Purpose: Two-flop synchroniser for one level.
// Assumes: Input is asynchronous to clk_sys.
// Notes: First stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module ssp_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic init_level,
    // Level in and out
    input wire logic din,
    output logic dout
);
    logic stage_a;
    logic stage_b;
    logic next_a;
    logic next_b;
    // ==========================================================
    // Synchroniser stages
    always_comb begin
        next_a = din;
        next_b = stage_a;
    end

    // Reset to idle; init is fixed per instance so stays constant
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stage_a <= init_level;
            stage_b <= init_level;
        end else begin
            stage_a <= next_a;
            stage_b <= next_b;
        end
    end
    assign dout = stage_b;
endmodule // ssp_sync
`default_nettype wire

// file: dv/ssp_peer.sv
// Purpose: Behavioural SPI peer on the far side of the port in master mode.
// Assumes: One byte per selection; edge roles set by tx_rise.
// Notes: Released data line is inverted so stale bits never pass.
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
    // Serial lines
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    // Byte setup and result
    input wire logic tx_rise,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    int cnt = 0;
    logic [7:0] sh = 8'h00;
    // ==========================================
    // Line behaviour
    initial miso = 1'b0;
    initial rx_byte = 8'h00;
    always @(sel_n) begin
        cnt = 0;
        miso = sel_n ? ~miso : tx_byte[7];
    end
    always @(sclk) begin
        if (!sel_n && sclk == tx_rise) begin
            miso = tx_byte[7 - cnt];
        end else if (!sel_n) begin
            sh = {sh[6:0], mosi};
            cnt = cnt + 1;
            if (cnt == 8) begin
                rx_byte = sh;
                cnt = 0;
            end
        end
    end
endmodule // ssp_peer
`default_nettype wire

// file: dv/ssp_port_properties.sv
// Purpose: Port-level properties of the serial shift buffer port.
// Assumes: Bound to ssp_port; one clock domain.
// Notes: Flags are judged one cycle after their strobe.
`timescale 1ns/1ps
`default_nettype none
module ssp_port_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Software strobes
    input wire logic ctl_wr,
    input wire logic [7:0] ctl_wdata,
    input wire logic stat_wr,
    input wire logic [7:0] stat_wdata,
    input wire logic buf_wr,
    input wire logic buf_rd,
    input wire logic irq_clear,
    // Registers and pins
    input wire logic [7:0] serial_control_one,
    input wire logic [7:0] serial_status_reg,
    input wire logic [7:0] serial_buffer_reg,
    input wire logic serial_irq_flag,
    input wire ssp_pkg::ssp_pins_s pins
);
    // ==========================================
    // Properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_collision_sticky: assert property (
        serial_control_one[7] && !ctl_wr |=> serial_control_one[7])
        else $error("collision flag dropped");
    a_collision_cause: assert property (
        $rose(serial_control_one[7]) |-> $past(buf_wr) || $past(ctl_wr))
        else $error("collision flag without a write");
    a_full_read_clears: assert property (
        buf_rd |=> !serial_status_reg[0] || $changed(serial_buffer_reg))
        else $error("full flag kept after read");
    a_full_raises_irq: assert property (
        $rose(serial_status_reg[0]) |-> serial_irq_flag)
        else $error("full set without interrupt flag");
    a_status_write: assert property (
        stat_wr |=> (serial_status_reg & ssp_pkg::STAT_RW_MASK) ==
        ($past(stat_wdata) & ssp_pkg::STAT_RW_MASK))
        else $error("status upper bits not written");
    a_control_write: assert property (
        ctl_wr |=> (serial_control_one & 8'h3F) == ($past(ctl_wdata) & 8'h3F))
        else $error("control bits not written");
    a_buffer_source: assert property (
        $changed(serial_buffer_reg) |-> $past(buf_wr) || $rose(serial_status_reg[0]))
        else $error("buffer changed without write or reception");
    a_master_clock_out: assert property (
        (serial_control_one[5] && serial_control_one[3:2] == 2'b00) [*2] |-> pins.sclk_oe)
        else $error("master does not drive clock");
    a_disabled_quiet: assert property (
        !serial_control_one[5] [*2] |-> !pins.sdo_oe && !pins.sclk_oe)
        else $error("disabled port drives a pin");
    a_irq_clear: assert property (
        irq_clear |=> !serial_irq_flag || $rose(serial_status_reg[0]))
        else $error("interrupt flag not cleared");
endmodule // ssp_port_checker
bind ssp_port ssp_port_checker ssp_port_checker_inst (.*);
`default_nettype wire

// file: dv/test_spi_shift_buffer_port.sv
// Purpose: Self-checking bench for the serial shift buffer port.
// Assumes: Inputs change on the falling edge of clk_sys.
// Notes: Peer answers master bytes; the bench is master in slave mode.
`timescale 1ns/1ps
`default_nettype none
module test_spi_shift_buffer_port;
    `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
    logic clk_sys = 1'b0, reset = 1'b1, timer_tick = 1'b0, sclk_in = 1'b0, sdi = 1'b0;
    logic ss_n = 1'b1, tx_rise = 1'b0, peer_sel_n = 1'b1, slave = 1'b0;
    logic peer_miso, serial_irq_flag;
    logic [4:0] stb = 5'h00;
    logic [7:0] wdata = 8'h00, peer_tx = 8'h00, peer_rx, got, b, m;
    logic [7:0] serial_control_one, serial_status_reg, serial_buffer_reg;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'hb0f1_a667;
    int miscompares = 0, total_checks = 0, cycles = 0, n;
    ssp_pkg::ssp_pins_s pins;
    // ==========================================
    // Design, peer and clocking
    ssp_port ssp_port_inst (.clk_sys(clk_sys), .reset(reset), .ctl_wr(stb[0]),
        .ctl_wdata(wdata), .stat_wr(stb[1]), .stat_wdata(wdata), .buf_wr(stb[2]),
        .buf_wdata(wdata), .buf_rd(stb[3]), .serial_control_one(serial_control_one),
        .serial_status_reg(serial_status_reg), .serial_buffer_reg(serial_buffer_reg),
        .serial_irq_flag(serial_irq_flag), .irq_clear(stb[4]), .timer_tick(timer_tick),
        .sclk_in(sclk_in), .sdi(slave ? sdi : peer_miso), .ss_n(ss_n), .pins(pins));
    ssp_peer ssp_peer_inst (.sel_n(peer_sel_n), .sclk(pins.sclk), .mosi(pins.sdo),
        .miso(peer_miso), .tx_rise(tx_rise), .tx_byte(peer_tx), .rx_byte(peer_rx));
    always #10 clk_sys = ~clk_sys;
    // Timer pulse every 4 clocks; a hang ends the run
    always @(negedge clk_sys) timer_tick <= (cycles % 4 == 0);
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    // One strobe: 0 ctl, 1 stat, 2 buf write, 3 buf read, 4 irq clear
    task automatic sw(input int k, input logic [7:0] v);
        @(negedge clk_sys);
        wdata = v;
        stb = 5'h01 << k;
        @(negedge clk_sys);
        stb = 5'h00;
    endtask
    task automatic wait_irq();
        n = 0;
        while (serial_irq_flag !== 1'b1 && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
    endtask
    // Bench as master: idle low, sample on rising, slow enough for the synchroniser
    task automatic shift(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            sdi = v[i];
            repeat (8) @(negedge clk_sys);
            got[i] = pins.sdo;
            sclk_in = 1'b1;
            repeat (8) @(negedge clk_sys);
            sclk_in = 1'b0;
        end
        sdi = ~sdi;
        repeat (8) @(negedge clk_sys);
    endtask
    task automatic test_done();
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (6) @(negedge clk_sys);
        reset = 1'b0;
        `CHK(serial_control_one, ssp_pkg::CTL_RESET)
        `CHK(serial_status_reg, ssp_pkg::STAT_RESET)
        b = rnd();
        sw(1, b);
        `CHK(serial_status_reg, b & 8'hC0)
        sw(0, b);
        `CHK(serial_control_one, b)
        // Every master rate, every polarity and phase pairing
        for (int i = 0; i < 4; i++) begin
            // Peer byte settles well before the select edge reads it
            tx_rise = i[1] ^ i[0];
            peer_tx = rnd();
            exp_q.push_back(peer_tx);
            sw(0, {3'b001, i[0], i[3:0]});
            sw(1, {1'b0, i[1], 6'h00});
            peer_sel_n = 1'b0;
            b = rnd();
            sw(2, b);
            `CHK(serial_buffer_reg, b)
            sw(2, ~b);
            `CHK(serial_control_one[7], 1'b1)
            `CHK(serial_buffer_reg, b)
            wait_irq();
            peer_sel_n = 1'b1;
            m = exp_q.pop_front();
            `CHK(serial_buffer_reg, m)
            `CHK(serial_status_reg[0], 1'b1)
            `CHK(peer_rx, b)
            `CHK(pins.sclk, i[0])
            sw(3, 8'h00);
            `CHK(serial_status_reg[0], 1'b0)
            sw(4, 8'h00);
        end
        // Slave with select, then an overflow while full
        slave = 1'b1;
        sw(0, 8'h24);
        sw(1, 8'h00);
        b = rnd();
        m = rnd();
        sw(2, b);
        ss_n = 1'b0;
        shift(m);
        `CHK(got, b)
        `CHK(pins.sdo_oe, 1'b1)
        `CHK(serial_buffer_reg, m)
        `CHK(serial_irq_flag, 1'b1)
        shift(~m);
        `CHK(serial_control_one[6], 1'b1)
        `CHK(serial_buffer_reg, m)
        ss_n = 1'b1;
        // Slave without select: select line stays high
        sw(0, 8'h25);
        sw(3, 8'h00);
        sw(4, 8'h00);
        b = rnd();
        m = rnd();
        sw(2, b);
        shift(m);
        `CHK(got, b)
        `CHK(serial_buffer_reg, m)
        // Code outside the SPI set leaves the port idle
        sw(4, 8'h00);
        sw(0, 8'h26);
        sw(2, rnd());
        repeat (40) @(negedge clk_sys);
        `CHK(pins.sclk_oe, 1'b0)
        `CHK(pins.sdo_oe, 1'b0)
        `CHK(serial_irq_flag, 1'b0)
        test_done();
    end
endmodule // test_spi_shift_buffer_port
`default_nettype wire
